// ### odtzq_pkg.sv
// Shared constants and command codes for the termination and calibration link
package odtzq_pkg;

    // Link command codes
    typedef enum logic [2:0] {
        ODTZQ_NOP = 3'h0,
        ODTZQ_MRS = 3'h1,
        ODTZQ_REF = 3'h2,
        ODTZQ_ACT = 3'h3,
        ODTZQ_PRE = 3'h4,
        ODTZQ_ZQCL = 3'h5,
        ODTZQ_ZQCS = 3'h6,
        ODTZQ_SRX = 3'h7
    } odtzq_cmd_t;

    // Mode register selects and fields
    localparam logic [1:0] MR_SEL_ZERO = 2'h0;
    localparam logic [1:0] MR_SEL_ONE = 2'h1;
    localparam logic [1:0] MR_SEL_TWO = 2'h2;
    localparam int unsigned MODE_ZERO_DLL_PD_BIT = 12;
    localparam int unsigned MODE_ZERO_CL_LSB = 4;
    localparam int unsigned MR1_AL_LSB = 3;
    localparam int unsigned MR2_CWL_LSB = 3;
    localparam logic [4:0] CL_BASE = 5'h04;
    localparam logic [4:0] CWL_BASE = 5'h05;
    localparam logic [2:0] CL_CODE_RST = 3'h0;
    localparam logic [1:0] AL_CODE_RST = 2'h0;
    localparam logic [2:0] CWL_CODE_RST = 3'h0;
    localparam logic DLL_PD_RST = 1'b0;

    // Clocking: link clock toggles every system cycle
    localparam int unsigned TSYS_PS = 4000;
    localparam int unsigned CK_HALF_SYS = 1;
    localparam int unsigned TCK_PS = TSYS_PS * 2 * CK_HALF_SYS;

    // Rounding helper for time to cycle conversion
    function automatic int unsigned cyc_up(input int unsigned ps);
        cyc_up = (ps + TCK_PS - 1) / TCK_PS;
        if (cyc_up == 0)
        begin
            cyc_up = 1;
        end
    endfunction : cyc_up

    // Times as printed, in picoseconds
    localparam int unsigned TAONPD_MIN_PS = 2000;
    localparam int unsigned TAOFPD_MIN_PS = 2000;
    localparam int unsigned TRFC_MIN_PS = 110000;
    localparam int unsigned TXPDLL_MIN_PS = 24000;
    localparam int unsigned TCPDED_MIN_PS = 1000;
    localparam int unsigned TXS_MIN_PS = 120000;
    localparam int unsigned TRP_MIN_PS = 13750;

    // Derived counts in link clock cycles
    localparam logic [4:0] TAONPD_CYC = 5'(cyc_up(TAONPD_MIN_PS));
    localparam logic [4:0] TAOFPD_CYC = 5'(cyc_up(TAOFPD_MIN_PS));
    localparam logic [4:0] TRFC_CYC = 5'(cyc_up(TRFC_MIN_PS));
    localparam logic [4:0] TXPDLL_CYC = 5'(cyc_up(TXPDLL_MIN_PS));
    localparam logic [4:0] TCPDED_CYC = 5'(cyc_up(TCPDED_MIN_PS));
    localparam logic [4:0] TXS_CYC = 5'(cyc_up(TXS_MIN_PS));
    localparam logic [4:0] TRP_CYC = 5'(cyc_up(TRP_MIN_PS));

    // Calibration windows, in link clock cycles
    localparam logic [9:0] TZQINIT_CYC = 10'h200;
    localparam logic [9:0] TZQOPER_CYC = 10'h100;
    localparam logic [9:0] TZQCS_CYC = 10'h040;

    // Depth of the termination request history
    localparam int unsigned HIST_W = 32;

endpackage : odtzq_pkg

// ### odtzq_link_if.sv
// Link between memory controller end and memory device end
`timescale 1ns/1ps
interface odtzq_link_if;
    import odtzq_pkg::*;
    logic ck;
    logic reset_n;
    logic cke;
    logic odt;
    odtzq_cmd_t cmd;
    logic [1:0] ba;
    logic [12:0] addr;

    // Controller drives everything
    modport host_mp (output ck, output reset_n, output cke, output odt, output cmd, output ba, output addr);
    // Device only listens
    modport dev_mp (input ck, input reset_n, input cke, input odt, input cmd, input ba, input addr);
endinterface : odtzq_link_if

// ### odtzq_dram_end.sv
// Device end: termination mode tracking and impedance calibration sequencing
// Contract
// - Frozen DLL power-down selects asynchronous termination
// - Asynchronous path ignores additive latency
// - Asynchronous turn-on within tAONPD bounds
// - Asynchronous turn-off within tAOFPD bounds
// - Frozen DLL allows either response near entry
// - Entry window starts WL-1 before CKE low
// - Entry window ends after tCPDED
// - Running refresh extends entry window to tRFC
// - Start point excluded, end points included
// - Window turn-on bounded by both timings
// - Window turn-off bounded by both timings
// - Exit window spans WL-1 before, tXPDLL after
// - Overlapping windows merge into one
// - Long calibration command runs and transfers
// - First long calibration tZQinit, later tZQoper
// - Short calibration finishes within tZQCS
// - Controller keeps channel quiet during calibration
// - Calibration current path off when done
// - Banks precharged and tRP before calibration
// - No self-refresh recalibration; tXS before command
// - Shared resistor ranks never calibrate together
// - CKE high, termination off during calibration
// - Synchronous latency equals CWL plus AL minus two
`timescale 1ns/1ps
module odtzq_dram_end (
    // System side
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Link from the controller
    odtzq_link_if.dev_mp link,
    // Status in the system clock domain
    output logic rtt_on,
    output logic async_mode,
    output logic in_window,
    output logic zq_busy,
    output logic cal_current,
    output logic proto_err,
    output logic odt_ambig,
    output logic zq_done
);
    import odtzq_pkg::*;

    logic [1:0] ce_sync;
    logic ce_l;
    logic dll_frz;
    logic [2:0] cl_code;
    logic [1:0] al_code;
    logic [2:0] cwl_code;
    logic [4:0] cl_v;
    logic [4:0] al_v;
    logic [4:0] wl_v;
    logic [4:0] odtl_idx;
    logic [4:0] anpd;
    logic cke_q;
    logic odt_q;
    logic pd;
    logic async_l;
    logic [4:0] win_cnt;
    logic [4:0] ref_cnt;
    logic [5:0] since_edge;
    logic amb_tg;
    logic [HIST_W-1:0] hist;
    logic rtt_l;
    logic [4:0] on_idx;
    logic [4:0] off_idx;
    logic [9:0] zq_cnt;
    logic zq_first;
    logic zq_tg;
    logic [4:0] txs_cnt;
    logic [4:0] trp_cnt;
    logic bank_open;
    logic err_l;
    logic [5:0] lvl_l;
    logic cke_fall;
    logic cke_rise;
    logic odt_chg;
    logic pd_event;
    logic zq_cmd;
    logic [5:0] lvl_s1;
    logic [5:0] lvl_s2;
    logic [1:0] tg_s1;
    logic [1:0] tg_s2;
    logic [1:0] tg_s3;

    // Larger of two cycle counts
    function automatic logic [4:0] max5(input logic [4:0] a, input logic [4:0] b);
        max5 = (a > b) ? a : b;
    endfunction : max5

    // Clock enable brought onto the link clock
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
            ce_sync <= 2'h0;
        else
            ce_sync <= {ce_sync[0], ce};
    end
    assign ce_l = ce_sync[1];

    // Edge detection on the registered link inputs
    assign cke_fall = cke_q & ~link.cke;
    assign cke_rise = ~cke_q & link.cke & pd;
    assign odt_chg = link.odt ^ odt_q;
    assign pd_event = dll_frz & (cke_fall | cke_rise);
    assign zq_cmd = (link.cmd == ODTZQ_ZQCL) || (link.cmd == ODTZQ_ZQCS);

    // Latencies from the mode registers
    assign cl_v = 5'(cl_code) + CL_BASE;
    assign al_v = (al_code == 2'h1) ? cl_v - 5'h01 : (al_code == 2'h2) ? cl_v - 5'h02 : 5'h00;
    assign wl_v = 5'(cwl_code) + CWL_BASE + al_v;
    assign odtl_idx = wl_v - 5'h03;
    assign anpd = wl_v - 5'h01;

    // Mode register writes
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
        begin
            dll_frz <= ~DLL_PD_RST;
            cl_code <= CL_CODE_RST;
            al_code <= AL_CODE_RST;
            cwl_code <= CWL_CODE_RST;
        end
        else if (ce_l && link.cmd == ODTZQ_MRS)
        begin
            case (link.ba)
                MR_SEL_ZERO:
                begin
                    dll_frz <= ~link.addr[MODE_ZERO_DLL_PD_BIT];
                    cl_code <= link.addr[MODE_ZERO_CL_LSB +: 3];
                end
                MR_SEL_ONE: al_code <= link.addr[MR1_AL_LSB +: 2];
                MR_SEL_TWO: cwl_code <= link.addr[MR2_CWL_LSB +: 3];
                default: ;
            endcase
        end
    end

    // Power-down state, termination mode and transition windows
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
        begin
            cke_q <= 1'b0;
            pd <= 1'b0;
            async_l <= 1'b0;
            win_cnt <= 5'h00;
        end
        else if (ce_l)
        begin
            cke_q <= link.cke;
            if (cke_fall)
            begin
                pd <= 1'b1;
                if (dll_frz)
                begin
                    async_l <= 1'b1;
                    win_cnt <= max5(win_cnt, max5(TCPDED_CYC, ref_cnt));
                end
            end
            else if (cke_rise)
            begin
                pd <= 1'b0;
                if (async_l)
                    win_cnt <= max5(win_cnt, TXPDLL_CYC);
            end
            else if (win_cnt != 5'h00)
            begin
                win_cnt <= win_cnt - 5'h01;
                if (win_cnt == 5'h01 && !pd)
                    async_l <= 1'b0;
            end
        end
    end

    // Refresh in progress, counted to its end point
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
            ref_cnt <= 5'h00;
        else if (ce_l)
        begin
            if (link.cmd == ODTZQ_REF)
                ref_cnt <= TRFC_CYC - 5'h01;
            else if (ref_cnt != 5'h00)
                ref_cnt <= ref_cnt - 5'h01;
        end
    end

    // Age of the last termination request edge, and ambiguous edges
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
        begin
            odt_q <= 1'b0;
            since_edge <= 6'h3f;
            amb_tg <= 1'b0;
        end
        else if (ce_l)
        begin
            odt_q <= link.odt;
            if (odt_chg)
                since_edge <= 6'h00;
            else if (since_edge != 6'h3f)
                since_edge <= since_edge + 6'h01;
            // Look back over the part before CKE was registered
            if ((pd_event && (odt_chg || since_edge < 6'(anpd) - 6'h01)) || (win_cnt != 5'h00 && odt_chg))
                amb_tg <= ~amb_tg;
        end
    end

    // Termination delay taps per mode
    assign on_idx = async_l ? TAONPD_CYC - 5'h01 : odtl_idx;
    assign off_idx = async_l ? TAOFPD_CYC - 5'h01 : odtl_idx;

    // Termination request history and internal termination state
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
        begin
            hist <= '0;
            rtt_l <= 1'b0;
        end
        else if (ce_l)
        begin
            hist <= {hist[HIST_W-2:0], link.odt};
            rtt_l <= rtt_l ? hist[off_idx] : hist[on_idx];
        end
    end

    // Calibration engine
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
        begin
            zq_cnt <= 10'h000;
            zq_first <= 1'b1;
            zq_tg <= 1'b0;
        end
        else if (ce_l)
        begin
            if (link.cmd == ODTZQ_ZQCL && zq_cnt == 10'h000)
            begin
                zq_cnt <= zq_first ? TZQINIT_CYC : TZQOPER_CYC;
                zq_first <= 1'b0;
            end
            else if (link.cmd == ODTZQ_ZQCS && zq_cnt == 10'h000)
                zq_cnt <= TZQCS_CYC;
            else if (zq_cnt != 10'h000)
            begin
                zq_cnt <= zq_cnt - 10'h001;
                if (zq_cnt == 10'h001)
                    zq_tg <= ~zq_tg;
            end
        end
    end

    // Bank, precharge and self-refresh exit timers
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
        begin
            bank_open <= 1'b0;
            trp_cnt <= 5'h00;
            txs_cnt <= 5'h00;
        end
        else if (ce_l)
        begin
            if (link.cmd == ODTZQ_ACT)
                bank_open <= 1'b1;
            else if (link.cmd == ODTZQ_PRE)
                bank_open <= 1'b0;
            if (link.cmd == ODTZQ_PRE)
                trp_cnt <= TRP_CYC;
            else if (trp_cnt != 5'h00)
                trp_cnt <= trp_cnt - 5'h01;
            // Exit alone starts no calibration
            if (link.cmd == ODTZQ_SRX)
                txs_cnt <= TXS_CYC;
            else if (txs_cnt != 5'h00)
                txs_cnt <= txs_cnt - 5'h01;
        end
    end

    // Sticky flag for controller misuse
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
            err_l <= 1'b0;
        else if (ce_l)
        begin
            if (zq_cmd && (bank_open || trp_cnt != 5'h00 || txs_cnt != 5'h00 || zq_cnt != 10'h000))
                err_l <= 1'b1;
            if (zq_cnt != 10'h000 && (link.cmd != ODTZQ_NOP || !link.cke || link.odt))
                err_l <= 1'b1;
        end
    end

    // Status levels registered before crossing
    always_ff @(posedge link.ck)
    begin
        if (!link.reset_n)
            lvl_l <= 6'h00;
        else if (ce_l)
            lvl_l <= {rtt_l, async_l, win_cnt != 5'h00, zq_cnt != 10'h000, zq_cnt > 10'h001, err_l};
    end

    // Crossing into the system clock domain
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            lvl_s1 <= 6'h00;
            lvl_s2 <= 6'h00;
            tg_s1 <= 2'h0;
            tg_s2 <= 2'h0;
            tg_s3 <= 2'h0;
            {rtt_on, async_mode, in_window, zq_busy, cal_current, proto_err} <= 6'h00;
            odt_ambig <= 1'b0;
            zq_done <= 1'b0;
        end
        else if (ce)
        begin
            lvl_s1 <= lvl_l;
            lvl_s2 <= lvl_s1;
            tg_s1 <= {amb_tg, zq_tg};
            tg_s2 <= tg_s1;
            tg_s3 <= tg_s2;
            {rtt_on, async_mode, in_window, zq_busy, cal_current, proto_err} <= lvl_s2;
            odt_ambig <= tg_s2[1] ^ tg_s3[1];
            zq_done <= tg_s2[0] ^ tg_s3[0];
        end
    end

endmodule : odtzq_dram_end

// ### odtzq_ctrl_end.sv
// Controller end: link clock divider, command issue and calibration guarding
`timescale 1ns/1ps
module odtzq_ctrl_end (
    // System side
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Command request
    input wire logic req_valid,
    input wire odtzq_pkg::odtzq_cmd_t req_cmd,
    input wire logic [1:0] req_ba,
    input wire logic [12:0] req_addr,
    output logic req_ready,
    // Level requests
    input wire logic pd_req,
    input wire logic odt_req,
    output logic zq_quiet,
    // Link to the device
    odtzq_link_if.host_mp link
);
    import odtzq_pkg::*;

    logic ck_q;
    logic upd;
    logic take;
    logic is_zq;
    logic legal;
    logic zq_first;
    logic bank_open;
    logic [9:0] zq_cnt;
    logic [4:0] trp_cnt;
    logic [4:0] txs_cnt;

    // Link clock falls on update cycles, so outputs settle before its rise
    assign upd = ce & ck_q;
    assign take = upd & req_valid & req_ready & legal;
    assign is_zq = (req_cmd == ODTZQ_ZQCL) || (req_cmd == ODTZQ_ZQCS);
    // One calibration at a time across everything on this controller
    assign legal = (zq_cnt == 10'h000) && (!is_zq || (!bank_open && trp_cnt == 5'h00 && txs_cnt == 5'h00
                   && link.cke && !pd_req));

    // Link clock divider and reset
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ck_q <= 1'b0;
            link.reset_n <= 1'b0;
        end
        else if (ce)
        begin
            ck_q <= ~ck_q;
            link.reset_n <= link.reset_n | ck_q; // Low over first ck rise
        end
    end
    assign link.ck = ck_q;

    // Ready only ahead of an update cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            req_ready <= 1'b0;
        else if (ce)
            req_ready <= ~ck_q & legal;
    end

    // Command, bank and address outputs
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            link.cmd <= ODTZQ_NOP;
            link.ba <= 2'h0;
            link.addr <= 13'h0000;
        end
        else if (upd)
        begin
            link.cmd <= take ? req_cmd : ODTZQ_NOP;
            link.ba <= take ? req_ba : 2'h0;
            link.addr <= take ? req_addr : 13'h0000;
        end
    end

    // Clock enable and termination request, both held during calibration
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            link.cke <= 1'b0;
            link.odt <= 1'b0;
        end
        else if (upd)
        begin
            link.cke <= (zq_cnt != 10'h000 || (take && is_zq)) ? 1'b1 : ~pd_req;
            link.odt <= odt_req && zq_cnt == 10'h000 && !(take && is_zq);
        end
    end

    // Quiet window mirrors the device calibration time
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            zq_cnt <= 10'h000;
            zq_first <= 1'b1;
        end
        else if (upd)
        begin
            if (take && req_cmd == ODTZQ_ZQCL)
            begin
                zq_cnt <= zq_first ? TZQINIT_CYC : TZQOPER_CYC;
                zq_first <= 1'b0;
            end
            else if (take && req_cmd == ODTZQ_ZQCS)
                zq_cnt <= TZQCS_CYC;
            else if (zq_cnt != 10'h000)
                zq_cnt <= zq_cnt - 10'h001;
        end
    end

    // Bank state and precharge and self-refresh exit timers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bank_open <= 1'b0;
            trp_cnt <= 5'h00;
            txs_cnt <= 5'h00;
        end
        else if (upd)
        begin
            if (take && req_cmd == ODTZQ_ACT)
                bank_open <= 1'b1;
            else if (take && req_cmd == ODTZQ_PRE)
                bank_open <= 1'b0;
            if (take && req_cmd == ODTZQ_PRE)
                trp_cnt <= TRP_CYC;
            else if (trp_cnt != 5'h00)
                trp_cnt <= trp_cnt - 5'h01;
            if (take && req_cmd == ODTZQ_SRX)
                txs_cnt <= TXS_CYC;
            else if (txs_cnt != 5'h00)
                txs_cnt <= txs_cnt - 5'h01;
        end
    end

    // Quiet status for the user
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            zq_quiet <= 1'b0;
        else if (ce)
            zq_quiet <= (zq_cnt != 10'h000);
    end

endmodule : odtzq_ctrl_end

// ### odtzq_link_props.sv
// Link assertions: calibration quiet span and its preconditions
`timescale 1ns/1ps
module odtzq_link_props (
    // Link signals
    input wire logic ck,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic odt,
    input wire odtzq_pkg::odtzq_cmd_t cmd,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr
);
    import odtzq_pkg::*;
    logic [9:0] quiet;
    logic zq_seen;
    logic bank_open;
    logic [3:0] srx_cnt;
    default clocking cb @(posedge ck); endclocking
    default disable iff (!reset_n);
    // Any calibration command
    sequence s_zq;
        cmd == ODTZQ_ZQCL || cmd == ODTZQ_ZQCS;
    endsequence
    // Calibration settled: channel idle, clock enabled, no termination
    sequence s_idle8;
        (cmd == ODTZQ_NOP && cke && !odt) [*8];
    endsequence
    // Quiet span left after a calibration command
    always_ff @(posedge ck or negedge reset_n)
    begin
        if (!reset_n)
            quiet <= 10'h000;
        else if (cmd == ODTZQ_ZQCL)
            quiet <= zq_seen ? TZQOPER_CYC : TZQINIT_CYC;
        else if (cmd == ODTZQ_ZQCS)
            quiet <= TZQCS_CYC;
        else if (quiet != 10'h000)
            quiet <= quiet - 10'h001;
    end
    // First long calibration since reset
    always_ff @(posedge ck or negedge reset_n)
    begin
        if (!reset_n)
            zq_seen <= 1'b0;
        else if (cmd == ODTZQ_ZQCL)
            zq_seen <= 1'b1;
    end
    // Open bank tracking
    always_ff @(posedge ck or negedge reset_n)
    begin
        if (!reset_n)
            bank_open <= 1'b0;
        else if (cmd == ODTZQ_ACT)
            bank_open <= 1'b1;
        else if (cmd == ODTZQ_PRE)
            bank_open <= 1'b0;
    end
    // Cycles left before calibration is allowed after self-refresh exit
    always_ff @(posedge ck or negedge reset_n)
    begin
        if (!reset_n)
            srx_cnt <= 4'h0;
        else if (cmd == ODTZQ_SRX)
            srx_cnt <= 4'(TXS_CYC) - 4'h1;
        else if (srx_cnt != 4'h0)
            srx_cnt <= srx_cnt - 4'h1;
    end
    chk_quiet_no_cmd: assert property (quiet > 10'h001 |-> cmd == ODTZQ_NOP)
        else $error("command inside calibration span");
    chk_quiet_cke_high: assert property (quiet > 10'h001 |-> cke)
        else $error("clock enable low during calibration");
    chk_quiet_odt_off: assert property (quiet > 10'h001 |-> !odt)
        else $error("termination requested during calibration");
    chk_zq_then_idle: assert property (s_zq |=> s_idle8)
        else $error("channel busy right after calibration command");
    chk_zq_bank_closed: assert property (s_zq |-> !bank_open && cke && !odt)
        else $error("calibration with bank open or link not ready");
    chk_zq_after_pre: assert property (s_zq |-> $past(cmd) != ODTZQ_PRE)
        else $error("calibration before precharge time");
    chk_zq_after_srx: assert property (s_zq |-> srx_cnt == 4'h0)
        else $error("calibration too soon after self-refresh exit");
    chk_zq_no_overlap: assert property (s_zq |-> quiet <= 10'h001)
        else $error("calibration spans overlap");
endmodule : odtzq_link_props

// ### odt_powerdown_zq_calibration_tb_top.sv
// Bench for both link ends: termination modes, windows and calibration
`timescale 1ns/1ps
module odt_powerdown_zq_calibration_tb_top;
    import odtzq_pkg::*;
    logic clk_sys, rst_n, req_valid, pd_req, odt_req, win_q;
    odtzq_cmd_t req_cmd;
    logic [1:0] req_ba;
    logic [12:0] req_addr;
    logic req_ready, zq_quiet, rtt_on, async_mode, in_window, zq_busy, cal_current, proto_err, odt_ambig, zq_done;
    int n_errors, comparisons, n_busy, n_cal, n_win, n_rise, n_done, n_amb, w, ds0, ds3, da0, da3, tmp;

    odtzq_link_if link ();
    odtzq_ctrl_end u_odtzq_ctrl_end (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr), .req_ready(req_ready), .pd_req(pd_req),
        .odt_req(odt_req), .zq_quiet(zq_quiet), .link(link));
    odtzq_dram_end u_odtzq_dram_end (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .link(link), .rtt_on(rtt_on),
        .async_mode(async_mode), .in_window(in_window), .zq_busy(zq_busy), .cal_current(cal_current),
        .proto_err(proto_err), .odt_ambig(odt_ambig), .zq_done(zq_done));
    odtzq_link_props u_odtzq_link_props (.ck(link.ck), .reset_n(link.reset_n), .cke(link.cke), .odt(link.odt),
        .cmd(link.cmd), .ba(link.ba), .addr(link.addr));

    // System clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Status activity counters
    always @(posedge clk_sys)
    begin
        n_busy += (zq_busy === 1'b1);
        n_cal += (cal_current === 1'b1);
        n_win += (in_window === 1'b1);
        n_rise += (in_window === 1'b1 && win_q !== 1'b1);
        n_done += (zq_done === 1'b1);
        n_amb += (odt_ambig === 1'b1);
        win_q = in_window;
    end

    task automatic clr();
        @(negedge clk_sys);
        {n_busy, n_cal, n_win, n_rise, n_done, n_amb} = '0;
    endtask : clr

    task automatic chk(input int got, input int exp, input string msg);
        comparisons++;
        if (got != exp)
        begin
            n_errors++;
            $display("Error at %0t: %s got %0d expected %0d", $time, msg, got, exp);
        end
    endtask : chk

    // Wait for the falling edge before a link update edge
    task automatic align();
        @(negedge clk_sys);
        while (link.ck !== 1'b1)
            @(negedge clk_sys);
    endtask : align

    // Hold a request until taken or until lim cycles pass
    task automatic issue(input odtzq_cmd_t c, input logic [1:0] b, input logic [12:0] a, input int lim,
        output int wt);
        wt = 0;
        align();
        @(negedge clk_sys);
        {req_valid, req_cmd, req_ba, req_addr} = {1'b1, c, b, a};
        while (req_ready !== 1'b1 && wt < lim)
        begin
            @(negedge clk_sys);
            wt++;
        end
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask : issue

    // Cycles from a termination request edge to the termination status
    task automatic odt_lat(input logic v, output int d);
        align();
        odt_req = v;
        d = 0;
        while (rtt_on !== v && d < 200)
        begin
            @(negedge clk_sys);
            d++;
        end
    endtask : odt_lat

    // Power-down with asynchronous termination, then exit
    task automatic pd_cycle(output int da);
        repeat (20) @(negedge clk_sys);
        clr();
        align();
        pd_req = 1'b1;
        repeat (20) @(negedge clk_sys);
        chk(async_mode === 1'b1, 1, "async in power-down");
        chk(n_win, 2 * TCPDED_CYC, "entry window");
        odt_lat(1'b1, da);
        odt_lat(1'b0, tmp);
        chk(tmp, da, "async turn-off");
        chk(n_amb, 0, "edges outside windows");
        repeat (20) @(negedge clk_sys);
        clr();
        align();
        pd_req = 1'b0;
        repeat (20) @(negedge clk_sys);
        chk(n_win, 2 * TXPDLL_CYC, "exit window");
        chk(async_mode === 1'b0, 1, "sync after exit");
    endtask : pd_cycle

    // Calibration span, refusal inside it, current path
    task automatic zq_run(input odtzq_cmd_t c, input int len);
        clr();
        issue(c, 2'h0, 13'h0000, 50, w);
        issue(ODTZQ_ZQCS, 2'h0, 13'h0000, 60, w);
        chk(w, 60, "refused while quiet");
        chk(zq_quiet === 1'b1, 1, "quiet window");
        repeat (2 * len + 20) @(negedge clk_sys);
        chk(n_busy, 2 * len, "calibration span");
        chk(n_done, 1, "one transfer");
        chk(n_cal > 0 && n_cal < n_busy, 1, "current off at end");
        chk(cal_current === 1'b0, 1, "current idle");
    endtask : zq_run

    task automatic report_and_stop();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // Watchdog
    initial
    begin
        #100000;
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        {rst_n, req_valid, pd_req, odt_req, req_ba, req_addr} = '0;
        req_cmd = ODTZQ_NOP;
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (20) @(negedge clk_sys);
        odt_lat(1'b1, ds0);
        odt_lat(1'b0, tmp);
        chk(tmp, ds0, "sync on equals off");
        chk(async_mode === 1'b0, 1, "sync when active");
        pd_cycle(da0);
        chk(ds0 - da0, 2 * (5 - 3), "sync vs async, WL 5");
        issue(ODTZQ_MRS, 2'h1, 13'h0008, 50, w);
        repeat (20) @(negedge clk_sys);
        odt_lat(1'b1, ds3);
        odt_lat(1'b0, tmp);
        chk(ds3 - ds0, 2 * 3, "additive latency in sync");
        pd_cycle(da3);
        chk(da3, da0, "no additive latency in async");
        clr();
        align();
        {pd_req, odt_req} = 2'b11;
        repeat (2) @(negedge clk_sys);
        pd_req = 1'b0;
        repeat (30) @(negedge clk_sys);
        chk(n_rise, 1, "merged windows");
        chk(n_amb > 0, 1, "edge inside window");
        odt_req = 1'b0;
        repeat (30) @(negedge clk_sys);
        issue(ODTZQ_MRS, 2'h0, 13'h1000, 50, w);
        clr();
        align();
        pd_req = 1'b1;
        repeat (20) @(negedge clk_sys);
        chk(async_mode === 1'b0, 1, "DLL kept on");
        chk(n_win, 0, "no window with DLL on");
        pd_req = 1'b0;
        repeat (20) @(negedge clk_sys);
        issue(ODTZQ_MRS, 2'h0, 13'h0000, 50, w);
        issue(ODTZQ_REF, 2'h0, 13'h0000, 50, w);
        clr();
        align();
        pd_req = 1'b1;
        repeat (40) @(negedge clk_sys);
        chk(n_win > 2 * TCPDED_CYC && n_win <= 2 * TRFC_CYC, 1, "refresh extends window");
        pd_req = 1'b0;
        repeat (30) @(negedge clk_sys);
        zq_run(ODTZQ_ZQCL, 512);
        zq_run(ODTZQ_ZQCL, 256);
        zq_run(ODTZQ_ZQCS, 64);
        issue(ODTZQ_ACT, 2'h0, 13'h0000, 50, w);
        issue(ODTZQ_ZQCS, 2'h0, 13'h0000, 40, w);
        chk(w, 40, "refused with bank open");
        issue(ODTZQ_PRE, 2'h0, 13'h0000, 50, w);
        issue(ODTZQ_ZQCS, 2'h0, 13'h0000, 40, w);
        chk(w < 40, 1, "taken after precharge");
        repeat (160) @(negedge clk_sys);
        issue(ODTZQ_SRX, 2'h0, 13'h0000, 50, w);
        issue(ODTZQ_ZQCS, 2'h0, 13'h0000, 80, w);
        chk(w >= 26 && w < 80, 1, "held off after self-refresh exit");
        repeat (160) @(negedge clk_sys);
        chk(proto_err === 1'b0, 1, "no misuse seen");
        report_and_stop();
    end
endmodule : odt_powerdown_zq_calibration_tb_top
